// ===== design/mic_pkg.sv
// Purpose: constants and types for the maskable interrupt control block
// Assumes: 8-bit register port, one 100 MHz clock
// Notes:   constants are used as mic_pkg::name, never imported
//
// What this block does
// - Three-bit priority field per source: 0 disables, 1..7 rising priority.
// - Request flag at bit 3 is cleared by writing 0; writing 1 is ignored.
// - Polarity bit 4 selects falling edge at 0, rising edge at 1.
// - Changing polarity may itself set the request flag.
// - Global enable flag clear blocks all maskable requests; set permits them.
// - Request flag sets on a request, clears when acknowledged and vectored.
// - Acknowledge needs enable set, flag set and level above threshold.
// - Outside an entry, enable, flags, levels and threshold never change one another.
// - Threshold n admits levels above n; threshold 7 blocks all.
// - Priority judged when the instruction ends; entry starts next cycle.
// - String and repeat-multiply instructions are suspended for entry.
// - Entry first reads vector information and clears the source flag.
// - Flags copied to hidden store; enable, single-step, stack-select cleared.
// - Software interrupts 32 to 63 keep the stack-select flag.
// - Entry pushes saved flags, then program counter, then loads vector.
// - Threshold takes the level of the acknowledged maskable request.
// - The entry sequence lasts a fixed 20 cycles.
// - Special entries set threshold 7; software entries leave it unchanged.
// - Equal levels are resolved by a fixed hardware order.
package mic_pkg;

  localparam int          NPIN = 4;
  localparam logic [NPIN-1:0][7:0] OFS_CTRL =
    {8'h5A, 8'h55, 8'h59, 8'h5D};
  localparam logic [7:0]  OFS_FLAGS = 8'h60;
  localparam logic [7:0]  OFS_IPL   = 8'h61;
  localparam logic [7:0]  OFS_STAT  = 8'h62;

  localparam int          LVL_LSB = 0;
  localparam int          IR_BIT  = 3;
  localparam int          POL_BIT = 4;
  localparam int          RSV_BIT = 5;
  localparam int          FI_BIT  = 0;
  localparam int          FD_BIT  = 1;
  localparam int          FU_BIT  = 2;

  localparam logic [2:0]  LVL_RST   = 3'h0;
  localparam logic        IR_RST    = 1'h0;
  localparam logic        POL_RST   = 1'h0;
  localparam logic        RSV_RST   = 1'h0;
  localparam logic        FLAG_RST  = 1'h0;
  localparam logic [2:0]  IPL_RST   = 3'h0;
  localparam logic [2:0]  IPL_BLOCK = 3'h7;
  localparam logic [5:0]  SW_U_LO   = 6'h20;

  localparam logic [4:0]  SEQ_CYCLES = 5'h14;
  localparam logic [4:0]  ST_INFO    = 5'h00;
  localparam logic [4:0]  ST_PUSHF   = 5'h04;
  localparam logic [4:0]  ST_PUSHPC  = 5'h08;
  localparam logic [4:0]  ST_IPL     = 5'h0C;
  localparam logic [4:0]  ST_LOADPC  = 5'h10;

  typedef enum logic [1:0] {K_MASK, K_SW, K_SPEC} mic_kind_t;

  typedef struct packed {
    logic [NPIN-1:0]      s1;
    logic [NPIN-1:0]      s2;
    logic [NPIN-1:0]      lvPrev;
    logic [NPIN-1:0][2:0] lvl;
    logic [NPIN-1:0]      ir;
    logic [NPIN-1:0]      edge_polarity;
    logic [NPIN-1:0]      rsv;
    logic                 flagI;
    logic                 flagD;
    logic                 flagU;
    logic [2:0]           processor_priority_threshold;
    logic                 active;
    logic [4:0]           step;
    mic_kind_t            kind;
    logic [1:0]           src;
    logic [2:0]           seqLvl;
    logic [5:0]           vec;
    logic [5:0]           saved;
    logic [7:0]           rdata;
    logic                 infoRead;
    logic                 pushFlags;
    logic                 pushPc;
    logic                 loadPc;
    logic                 suspend;
  } mic_state_t;

endpackage

// ===== design/mic_top.sv
// Purpose: maskable interrupt control for four external pin sources
// Assumes: core signals are on clk; intPin comes from pads
// Notes:   entry sequence is driven here, the core follows its strobes
`timescale 1ns/1ps
module mic_top #(
  parameter logic [3:0][5:0] PIN_VEC = {6'h1B, 6'h1A, 6'h19, 6'h1D}
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic [3:0] intPin,
  input  wire logic       instrDone,
  input  wire logic       stringBusy,
  input  wire logic       swReq,
  input  wire logic [5:0] swNum,
  input  wire logic       specReq,
  input  wire logic [5:0] specNum,
  output logic            entryBusy,
  output logic            infoRead,
  output logic            pushFlags,
  output logic            pushPc,
  output logic            loadPc,
  output logic            suspendInstr,
  output logic      [5:0] vectorNum,
  output logic      [5:0] savedFlags,
  output logic            intEnable,
  output logic      [2:0] threshold
);

  mic_pkg::mic_state_t r;
  mic_pkg::mic_state_t next_r;
  logic [3:0] edgeHit;
  logic [3:0] wrCtrl;
  logic       found;
  logic [1:0] win;
  logic [2:0] winLvl;
  logic       maskOk;
  logic       eval;
  logic       accept;

  always_comb begin
    logic lv;
    lv      = 1'b0;
    next_r  = r;
    found   = 1'b0;
    win     = 2'h0;
    winLvl  = 3'h0;
    edgeHit = 4'h0;
    wrCtrl  = 4'h0;
    next_r.s1        = intPin;
    next_r.s2        = r.s1;
    next_r.infoRead  = 1'b0;
    next_r.pushFlags = 1'b0;
    next_r.pushPc    = 1'b0;
    next_r.loadPc    = 1'b0;
    next_r.suspend   = 1'b0;
    next_r.rdata     = 8'h00;

    // Polarity folds into the level, so a polarity flip can look like an edge
    for (int i = 0; i < mic_pkg::NPIN; i++) begin
      lv = r.s2[i] ~^ r.edge_polarity[i];
      next_r.lvPrev[i] = lv;
      edgeHit[i] = lv & ~r.lvPrev[i];
      wrCtrl[i] = wr && (addr == mic_pkg::OFS_CTRL[i]);
    end

    // Lowest index wins a tie of levels
    for (int i = mic_pkg::NPIN - 1; i >= 0; i--) begin
      if (r.ir[i] && r.lvl[i] != 3'h0 && r.lvl[i] >= winLvl) begin
        found  = 1'b1;
        win    = 2'(i);
        winLvl = r.lvl[i];
      end
    end
    maskOk = r.flagI && found && (winLvl > r.processor_priority_threshold);
    eval   = !r.active && (instrDone || stringBusy);
    accept = eval && (specReq || swReq || maskOk);

    // Each field has its own write path only
    for (int i = 0; i < mic_pkg::NPIN; i++) begin
      if (wrCtrl[i]) begin
        next_r.lvl[i] = wdata[mic_pkg::LVL_LSB +: 3];
        next_r.edge_polarity[i] = wdata[mic_pkg::POL_BIT];
        next_r.rsv[i] = wdata[mic_pkg::RSV_BIT];
        if (!wdata[mic_pkg::IR_BIT])
          next_r.ir[i] = 1'b0;
      end
    end
    if (wr && addr == mic_pkg::OFS_FLAGS) begin
      next_r.flagI = wdata[mic_pkg::FI_BIT];
      next_r.flagD = wdata[mic_pkg::FD_BIT];
      next_r.flagU = wdata[mic_pkg::FU_BIT];
    end
    if (wr && addr == mic_pkg::OFS_IPL)
      next_r.processor_priority_threshold = wdata[2:0];

    if (accept) begin
      next_r.active   = 1'b1;
      next_r.step     = mic_pkg::ST_INFO;
      next_r.infoRead = 1'b1;
      next_r.suspend  = !instrDone && stringBusy;
      next_r.saved    = {r.processor_priority_threshold, r.flagU, r.flagD, r.flagI};
      next_r.flagI    = 1'b0;
      next_r.flagD    = 1'b0;
      if (specReq) begin
        next_r.kind  = mic_pkg::K_SPEC;
        next_r.vec   = specNum;
        next_r.flagU = 1'b0;
      end else if (swReq) begin
        next_r.kind = mic_pkg::K_SW;
        next_r.vec  = swNum;
        if (swNum < mic_pkg::SW_U_LO)
          next_r.flagU = 1'b0;
      end else begin
        next_r.kind   = mic_pkg::K_MASK;
        next_r.src    = win;
        next_r.seqLvl = winLvl;
        next_r.vec    = PIN_VEC[win];
        next_r.flagU  = 1'b0;
        next_r.ir[win] = 1'b0;
      end
    end else if (r.active) begin
      next_r.step = r.step + 5'h01;
      if (r.step == mic_pkg::SEQ_CYCLES - 5'h01) begin
        next_r.active = 1'b0;
        next_r.step   = mic_pkg::ST_INFO;
      end
      if (next_r.step == mic_pkg::ST_PUSHF && next_r.active)
        next_r.pushFlags = 1'b1;
      if (next_r.step == mic_pkg::ST_PUSHPC)
        next_r.pushPc = 1'b1;
      if (next_r.step == mic_pkg::ST_LOADPC)
        next_r.loadPc = 1'b1;
      if (r.step == mic_pkg::ST_IPL - 5'h01) begin
        if (r.kind == mic_pkg::K_MASK)
          next_r.processor_priority_threshold = r.seqLvl;
        else if (r.kind == mic_pkg::K_SPEC)
          next_r.processor_priority_threshold = mic_pkg::IPL_BLOCK;
      end
    end

    // A new edge wins over any clear in the same cycle
    for (int i = 0; i < mic_pkg::NPIN; i++) begin
      if (edgeHit[i])
        next_r.ir[i] = 1'b1;
    end

    if (rd) begin
      for (int i = 0; i < mic_pkg::NPIN; i++) begin
        if (addr == mic_pkg::OFS_CTRL[i])
          next_r.rdata = {2'h0, r.rsv[i], r.edge_polarity[i], r.ir[i], r.lvl[i]};
      end
      case (addr)
        mic_pkg::OFS_FLAGS:
          next_r.rdata = {5'h00, r.flagU, r.flagD, r.flagI};
        mic_pkg::OFS_IPL:  next_r.rdata = {5'h00, r.processor_priority_threshold};
        mic_pkg::OFS_STAT: next_r.rdata = {r.active, 5'h00, r.src};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r        <= '0;
      r.lvPrev <= 4'hF;
      r.lvl    <= {4{mic_pkg::LVL_RST}};
      r.ir     <= {4{mic_pkg::IR_RST}};
      r.edge_polarity    <= {4{mic_pkg::POL_RST}};
      r.rsv    <= {4{mic_pkg::RSV_RST}};
      r.flagI  <= mic_pkg::FLAG_RST;
      r.processor_priority_threshold    <= mic_pkg::IPL_RST;
      r.kind   <= mic_pkg::K_MASK;
    end else begin
      r <= next_r;
    end
  end

  assign rdata        = r.rdata;
  assign entryBusy    = r.active;
  assign infoRead     = r.infoRead;
  assign pushFlags    = r.pushFlags;
  assign pushPc       = r.pushPc;
  assign loadPc       = r.loadPc;
  assign suspendInstr = r.suspend;
  assign vectorNum    = r.vec;
  assign savedFlags   = r.saved;
  assign intEnable    = r.flagI;
  assign threshold    = r.processor_priority_threshold;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence sPushes;
    ##4 pushFlags ##4 pushPc;
  endsequence
  sequence sLoad;
    ##16 loadPc;
  endsequence

  a_edge_sets_flag:
    assert property (edgeHit[0] |=> r.ir[0])
    else $error("pin edge did not set request flag");
  a_ir_write_one:
    assert property (wrCtrl[1] && wdata[3] && !r.ir[1] && !edgeHit[1]
                     |=> !r.ir[1])
    else $error("writing one set the request flag");
  a_enable_gates:
    assert property (eval && !r.flagI && !specReq && !swReq |=> !r.active)
    else $error("entry taken with enable clear");
  a_thresh_blocks:
    assert property (eval && r.processor_priority_threshold == 3'h7 && !specReq && !swReq
                     |=> !r.active)
    else $error("entry taken at threshold seven");
  a_seq_length:
    assert property ($rose(r.active) |-> ##19 r.active ##1 !r.active)
    else $error("entry sequence not 20 cycles");
  a_entry_order:
    assert property (infoRead |-> sPushes and sLoad)
    else $error("push and load out of order");
  a_flags_clear:
    assert property (infoRead && r.kind != mic_pkg::K_SW
                     |-> !r.flagI && !r.flagD && !r.flagU)
    else $error("flags not cleared at entry");
  a_sw_keeps_u:
    assert property (accept && !specReq && swReq && swNum >= 6'h20
                     |=> r.flagU == $past(r.flagU))
    else $error("stack select changed for high software number");
  a_ipl_loads:
    assert property (r.active && r.step == 5'h0B && r.kind == mic_pkg::K_MASK
                     |=> r.processor_priority_threshold == $past(r.seqLvl))
    else $error("threshold not loaded with level");
  a_ack_clears:
    assert property (accept && !specReq && !swReq && !edgeHit[win]
                     |=> !r.ir[r.src])
    else $error("acknowledged flag not cleared");

  a_info_pulse:
    assert property (infoRead |=> !infoRead)
    else $error("vector information read longer than one cycle");

  a_no_eval_idle:
    assert property (!eval && !r.active |=> !r.active)
    else $error("entry started outside an instruction boundary");

  a_suspend_pair:
    assert property (suspendInstr |-> infoRead)
    else $error("suspend pulse without entry start");

  a_spec_blocks:
    assert property (r.active && r.step == mic_pkg::ST_IPL - 5'h01
                     && r.kind == mic_pkg::K_SPEC
                     |=> r.processor_priority_threshold == mic_pkg::IPL_BLOCK)
    else $error("special entry did not block threshold");

  a_sw_keeps_ipl:
    assert property (r.active && r.step == mic_pkg::ST_IPL - 5'h01
                     && r.kind == mic_pkg::K_SW
                     && !(wr && addr == mic_pkg::OFS_IPL)
                     |=> $stable(r.processor_priority_threshold))
    else $error("software entry changed threshold");

  a_level_zero:
    assert property (accept && !specReq && !swReq
                     |-> r.lvl[win] != 3'h0)
    else $error("disabled source acknowledged");

  a_ack_terms:
    assert property (accept && !specReq && !swReq
                     |-> r.ir[win] && r.flagI && r.lvl[win] > r.processor_priority_threshold)
    else $error("acknowledge without all three conditions");

  a_tie_lowest:
    assert property (accept && !specReq && !swReq && r.ir[0]
                     && r.lvl[0] == winLvl |-> win == 2'h0)
    else $error("tie not resolved to lowest pin");

  a_ipl_alone:
    assert property (!r.active && !(wr && addr == mic_pkg::OFS_IPL)
                     |=> $stable(r.processor_priority_threshold))
    else $error("threshold changed without a write");

  a_enable_alone:
    assert property (!accept && !(wr && addr == mic_pkg::OFS_FLAGS)
                     |=> $stable(r.flagI))
    else $error("enable changed without a write");

  a_flags_saved:
    assert property (infoRead
                     |-> r.saved == {$past(r.processor_priority_threshold), $past(r.flagU),
                                     $past(r.flagD), $past(r.flagI)})
    else $error("saved flag copy wrong");

  a_rdata_idle:
    assert property (!rd |=> rdata == 8'h00)
    else $error("read data without a read strobe");

endmodule

// ===== tb/mic_core_model.sv
// Purpose: core model that ends instructions or runs a string instruction
// Assumes: one clock, synchronous active-low reset
// Notes:   no instruction ends while the entry sequence owns the core
`timescale 1ns/1ps
module mic_core_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic entryBusy,
  input  wire logic strMode,
  output logic      instrDone,
  output logic      stringBusy
);
  logic [2:0] cnt;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt       <= 3'h0;
      instrDone <= 1'b0;
    end else begin
      cnt       <= entryBusy ? 3'h0 : cnt + 3'h1;
      instrDone <= !strMode && !entryBusy && cnt == 3'h7;
    end
  end
  // Long string work never completes by itself, so entry must suspend it
  assign stringBusy = strMode && !entryBusy;
endmodule

// ===== tb/mic_top_tb.sv
// Purpose: self-checking bench for the interrupt control block
// Assumes: pins idle high; core model supplies instruction boundaries
// Notes:   seed fixed, so every run repeats the same levels
`timescale 1ns/1ps
module mic_top_tb;
  logic       clk, nrst, wr, rd, instrDone, stringBusy;
  logic       swReq, specReq, strMode, entryBusy, suspendInstr, intEnable;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] intPin;
  logic [5:0] swNum, specNum, vectorNum;
  logic [2:0] threshold, l, t;
  logic       en;
  int         miscompares, checked;
  mic_top i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .intPin(intPin),
    .instrDone(instrDone), .stringBusy(stringBusy), .swReq(swReq),
    .swNum(swNum), .specReq(specReq), .specNum(specNum),
    .entryBusy(entryBusy), .infoRead(), .pushFlags(), .pushPc(),
    .loadPc(), .suspendInstr(suspendInstr), .vectorNum(vectorNum),
    .savedFlags(), .intEnable(intEnable), .threshold(threshold));
  mic_core_model i_core (.clk(clk), .nrst(nrst), .entryBusy(entryBusy),
    .strMode(strMode), .instrDone(instrDone), .stringBusy(stringBusy));
  task automatic end_sim;
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdReg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  task automatic pin(input int i, input logic v);
    @(posedge clk);
    intPin[i] <= v;
    repeat (4) @(posedge clk);
  endtask
  // Waits for entry, then measures its length and end state
  task automatic entry(input logic [5:0] v, input logic [2:0] th, logic s);
    int n;
    n = 0;
    #1;
    while (entryBusy !== 1'b1 && n < 60) begin
      @(posedge clk); #1 n++;
    end
    chk("suspend", {7'h0, s}, {7'h0, suspendInstr});
    n = 0;
    while (entryBusy === 1'b1 && n < 40) begin
      @(posedge clk);
      swReq <= 1'b0; specReq <= 1'b0;
      #1 n++;
    end
    chk("busyLen", 8'h14, 8'(n));
    chk("vector", {2'h0, v}, {2'h0, vectorNum});
    chk("thresh", {5'h0, th}, {5'h0, threshold});
    chk("enable", 8'h00, {7'h0, intEnable});
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000 miscompares++;
    end_sim();
  end
  initial begin
    nrst = 0; wr = 0; rd = 0; addr = 0; wdata = 0; intPin = 4'hF;
    swReq = 0; specReq = 0; swNum = 0; specNum = 0; strMode = 0;
    miscompares = 0; checked = 0;
    void'($urandom(35));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) rdReg(mic_pkg::OFS_CTRL[i], 8'h00);
    rdReg(8'h33, 8'h00);
    wrReg(mic_pkg::OFS_CTRL[1], 8'h0D);
    rdReg(mic_pkg::OFS_CTRL[1], 8'h05);
    for (int k = 0; k < 8; k++) begin
      l = 3'($urandom_range(1, 7)); t = 3'($urandom_range(0, 7));
      en = k == 0 ? 1'b0 : 1'($urandom_range(0, 1));
      wrReg(mic_pkg::OFS_CTRL[0], {5'h0, l});
      wrReg(mic_pkg::OFS_IPL, {5'h0, t});
      wrReg(mic_pkg::OFS_FLAGS, {7'h0, en});
      pin(0, 1'b0);
      if (en && l > t) begin
        entry(6'h1D, l, 1'b0);
        rdReg(mic_pkg::OFS_CTRL[0], {5'h0, l});
      end else begin
        repeat (30) @(posedge clk);
        chk("busy", 8'h00, {7'h0, entryBusy});
        rdReg(mic_pkg::OFS_CTRL[0], {4'h0, 1'b1, l});
        wrReg(mic_pkg::OFS_FLAGS, 8'h00);
      end
      pin(0, 1'b1);
      wrReg(mic_pkg::OFS_CTRL[0], 8'h00);
    end
    wrReg(mic_pkg::OFS_CTRL[0], 8'h03);
    wrReg(mic_pkg::OFS_CTRL[1], 8'h03);
    wrReg(mic_pkg::OFS_IPL, 8'h00);
    pin(0, 1'b0); pin(1, 1'b0);
    wrReg(mic_pkg::OFS_FLAGS, 8'h01);
    entry(6'h1D, 3'h3, 1'b0);
    wrReg(mic_pkg::OFS_FLAGS, 8'h01);
    repeat (30) @(posedge clk);
    chk("busy", 8'h00, {7'h0, entryBusy});
    wrReg(mic_pkg::OFS_IPL, 8'h00);
    entry(6'h19, 3'h3, 1'b0);
    wrReg(mic_pkg::OFS_CTRL[3], 8'h10);
    rdReg(mic_pkg::OFS_CTRL[3], 8'h18);
    wrReg(mic_pkg::OFS_CTRL[3], 8'h10);
    pin(3, 1'b0);
    rdReg(mic_pkg::OFS_CTRL[3], 8'h10);
    pin(3, 1'b1);
    rdReg(mic_pkg::OFS_CTRL[3], 8'h18);
    strMode <= 1'b1;
    @(posedge clk);
    specReq <= 1'b1; specNum <= 6'h0A;
    entry(6'h0A, 3'h7, 1'b1);
    strMode <= 1'b0; swReq <= 1'b1; swNum <= 6'h25;
    entry(6'h25, 3'h7, 1'b0);
    end_sim();
  end
endmodule
